// file: src/ds3_sts1_spe_mapper.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Envelope is 87 columns by 9 rows, POH first
// - Each row carries 59 fixed filler bits
// - Each row carries 621 dedicated DS3 data bits
// - One stuff opportunity bit in every row
// - Five indicator bits: 0 data, 1 stuff
// - Two communication bits per row, optional user
// - Framed DS3 overhead travels as plain data
// - Stuff decision follows DS3 versus SONET timing
// - 8000 envelopes per second from SONET rate
// - Nominal envelope carries 5592 DS3 bits
// - Ideal rate: three data, six stuff opportunities

`include "ds3_map_params.svh"

module ds3_sts1_spe_mapper #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH,
    parameter int SPE_PERIOD_CYC = `SPE_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // DS3 bit stream in
    input wire logic ds3Bit,
    input wire logic ds3Valid,
    output logic ds3Ready,
    // Overhead communication bits
    input wire logic [1:0] commBits,
    // Envelope byte stream out
    output logic [7:0] speByte,
    output logic speValid,
    output logic speFirst,
    output logic pohSlot,
    // Status
    output logic rowStuffData,
    output logic underrun
);
    ds3_map_pkg::mapper_state_type s, next_s;
    ds3_map_pkg::bit_kind_type kind;
    logic tick;
    logic pop;
    logic needData;
    logic bitVal;
    logic nominalRow;
    logic [17:0] accSum;
    logic signed [14:0] newDebt;

    stream_if #(.W(1)) inFifo ();
    stream_if #(.W(1)) outFifo ();

    assign inFifo.valid = ds3Valid;
    assign inFifo.data = ds3Bit;
    assign outFifo.ready = pop;

    stream_fifo #(
        .W(1),
        .DEPTH(FIFO_DEPTH)
    ) bitBuffer (
        .clk(clk),
        .resetn(resetn),
        .inPort(inFifo.snk),
        .outPort(outFifo.src)
    );

    assign ds3Ready = inFifo.ready;
    assign speByte = s.speByte;
    assign speValid = s.speValid;
    assign speFirst = s.speFirst;
    assign pohSlot = s.pohSlot;
    assign rowStuffData = s.stuffData;
    assign underrun = s.underrun;

    // Rows 2, 5 and 8 take data in their opportunity bit at nominal rate
    assign nominalRow = (s.row % 4'h3) == 4'h2;

    always_comb begin
        next_s = s;
        next_s.speValid = 1'b0;
        next_s.speFirst = 1'b0;
        next_s.pohSlot = 1'b0;
        next_s.underrun = 1'b0;
        pop = 1'b0;
        bitVal = `FIXED_FILL;
        newDebt = 15'(s.debt);
        kind = ds3_map_pkg::kind_of(s.idx, s.bitIdx);
        needData = (kind == ds3_map_pkg::KIND_DATA) ||
                   (kind == ds3_map_pkg::KIND_OPP && s.stuffData);

        // Byte clock of the SONET side, exact fraction of the system clock
        accSum = {1'b0, s.acc} + 18'(`BYTE_RATE_KHZ);
        tick = accSum >= 18'(`SYS_CLK_KHZ);
        if (tick) begin
            next_s.acc = 17'(accSum - 18'(`SYS_CLK_KHZ));
        end else begin
            next_s.acc = accSum[16:0];
        end

        if (ds3Valid && inFifo.ready) begin
            next_s.bitsIn = s.bitsIn + 13'h1;
        end

        // Serial assembly of one payload byte, first bit in the MSB
        if (s.phase == ds3_map_pkg::ASM_RUN) begin
            if (needData) begin
                pop = outFifo.valid;
                bitVal = outFifo.valid & outFifo.data[0];
                next_s.underrun = !outFifo.valid;
            end else if (kind == ds3_map_pkg::KIND_CTRL) begin
                bitVal = !s.stuffData;
            end else if (kind == ds3_map_pkg::KIND_COMM) begin
                bitVal = commBits[!s.bitIdx[0]];
            end else begin
                bitVal = `FIXED_FILL;
            end
            next_s.shift = {s.shift[6:0], bitVal};
            next_s.bitIdx = s.bitIdx + 3'h1;
            if (s.bitIdx == 3'h7) begin
                next_s.speByte = {s.shift[6:0], bitVal};
                next_s.speValid = 1'b1;
                next_s.phase = ds3_map_pkg::ASM_IDLE;
            end
        end

        if (tick) begin
            // Envelope held aligned to the frame, TOH columns send nothing
            if (s.col == 7'(`FRAME_COLS - 1)) begin
                next_s.col = 7'h00;
                next_s.row = (s.row == 4'(`SPE_ROWS - 1)) ? 4'h0 : s.row + 4'h1;
            end else begin
                next_s.col = s.col + 7'h01;
            end
            if (s.col == 7'(`POH_COL)) begin
                next_s.speByte = `POH_FILL;
                next_s.speValid = 1'b1;
                next_s.pohSlot = 1'b1;
                next_s.speFirst = s.row == 4'h0;
                if (s.row == 4'h0) begin
                    next_s.bitsIn = (ds3Valid && inFifo.ready) ? 13'h1 : 13'h0;
                    next_s.primed = 1'b1;
                    if (s.primed) begin
                        // Bits taken in during the last envelope against the nominal count
                        newDebt = newDebt + 15'(s.bitsIn) - 15'(`BITS_PER_SPE);
                    end
                end
                if (nominalRow && newDebt < 15'sd0) begin
                    next_s.stuffData = 1'b0;
                    newDebt = newDebt + 15'sd1;
                end else if (!nominalRow && newDebt > 15'sd0) begin
                    next_s.stuffData = 1'b1;
                    newDebt = newDebt - 15'sd1;
                end else begin
                    next_s.stuffData = nominalRow;
                end
                if (newDebt > 15'sd127) begin
                    newDebt = 15'sd127;
                end else if (newDebt < -15'sd127) begin
                    newDebt = -15'sd127;
                end
                next_s.debt = 8'(newDebt);
            end else if (s.col > 7'(`POH_COL)) begin
                next_s.phase = ds3_map_pkg::ASM_RUN;
                next_s.bitIdx = 3'h0;
                next_s.idx = 7'(s.col - 7'(`POH_COL) - 7'h01);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Checking helpers
    localparam int PAY_LAT = 9;
    logic pohTick;
    logic [9:0] kindCnt [5];
    logic [12:0] speBits;
    logic [3:0] speOpp;
    logic [15:0] cycCnt;
    logic speSeen;

    assign pohTick = tick && s.col == 7'(`POH_COL);

    generate
        for (genvar k = 0; k < 5; k++) begin : g_kind
            always_ff @(posedge clk) begin
                if (!resetn || pohTick) begin
                    kindCnt[k] <= 10'h000;
                end else if (s.phase == ds3_map_pkg::ASM_RUN && kind == ds3_map_pkg::bit_kind_type'(k)) begin
                    kindCnt[k] <= kindCnt[k] + 10'h001;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!resetn || (pohTick && s.row == 4'h0)) begin
            speBits <= 13'h0000;
            speOpp <= 4'h0;
        end else if (s.phase == ds3_map_pkg::ASM_RUN && needData) begin
            speBits <= speBits + 13'h0001;
            if (kind == ds3_map_pkg::KIND_OPP) begin
                speOpp <= speOpp + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cycCnt <= 16'h0000;
            speSeen <= 1'b0;
        end else begin
            cycCnt <= s.speFirst ? 16'h0000 : cycCnt + 16'h0001;
            speSeen <= speSeen | s.speFirst;
        end
    end

    // Comm inputs one cycle late, as the assembler sampled them
    logic [1:0] commPrev;

    always_ff @(posedge clk) begin
        commPrev <= commBits;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence payTick;
        tick && s.col > 7'(`POH_COL);
    endsequence

    sequence byteOut;
        ##PAY_LAT (s.speValid && !s.pohSlot);
    endsequence

    a_payload_byte: assert property (payTick |-> byteOut)
        else $error("payload byte not produced nine cycles after its slot");

    a_poh_byte: assert property (pohTick |=> s.speValid && s.pohSlot && s.speByte == `POH_FILL)
        else $error("overhead byte missing in its column");

    a_fixed_bits: assert property (pohTick && s.primed |-> kindCnt[0] == 10'(`FIXED_PER_ROW))
        else $error("row fixed filler count wrong");

    a_data_bits: assert property (pohTick && s.primed |-> kindCnt[1] == 10'(`DATA_PER_ROW))
        else $error("row data bit count wrong");

    a_ctrl_bits: assert property (pohTick && s.primed |-> kindCnt[2] == 10'(`CTRL_PER_ROW))
        else $error("row indicator bit count wrong");

    a_opp_bits: assert property (pohTick && s.primed |-> kindCnt[3] == 10'(`OPP_PER_ROW))
        else $error("row opportunity bit count wrong");

    a_comm_bits: assert property (pohTick && s.primed |-> kindCnt[4] == 10'(`COMM_PER_ROW))
        else $error("row communication bit count wrong");

    a_ctrl_value: assert property (s.phase == ds3_map_pkg::ASM_RUN && kind == ds3_map_pkg::KIND_CTRL
                                   |=> s.shift[0] == !s.stuffData)
        else $error("indicator bit disagrees with row decision");

    a_spe_total: assert property (pohTick && s.row == 4'h0 && s.primed
                                  |-> speBits == 13'(`DATA_PER_SPE) + 13'(speOpp))
        else $error("envelope data total does not match opportunity use");

    a_spe_period: assert property (s.speFirst && speSeen |-> cycCnt == 16'(SPE_PERIOD_CYC - 1))
        else $error("envelope period wrong");

    a_nominal_use: assert property (pohTick && s.row != 4'h0 && s.debt == 8'sd0
                                    |=> s.stuffData == $past(nominalRow))
        else $error("balanced decision departs from nominal pattern");

    a_just_extra: assert property (pohTick && s.row != 4'h0 && s.debt > 8'sd0 && !nominalRow
                                   |=> s.stuffData && s.debt == $past(s.debt) - 8'sd1)
        else $error("excess input not absorbed by opportunity bit");

    a_just_short: assert property (pohTick && s.row != 4'h0 && s.debt < 8'sd0 && nominalRow
                                   |=> !s.stuffData && s.debt == $past(s.debt) + 8'sd1)
        else $error("input shortfall not absorbed by opportunity bit");

    a_first_poh: assert property (s.speFirst |-> s.speValid && s.pohSlot)
        else $error("envelope start not on overhead byte");

    a_row_wrap: assert property (tick && s.col == 7'(`FRAME_COLS - 1) && s.row == 4'(`SPE_ROWS - 1)
                                 |=> s.col == 7'h00 && s.row == 4'h0)
        else $error("frame counter does not wrap after last row");

    a_fixed_zero: assert property (s.phase == ds3_map_pkg::ASM_RUN && kind == ds3_map_pkg::KIND_FIXED
                                   |=> s.shift[0] == `FIXED_FILL)
        else $error("fixed filler bit not at fill value");

    a_stuff_zero: assert property (s.phase == ds3_map_pkg::ASM_RUN && kind == ds3_map_pkg::KIND_OPP
                                   && !s.stuffData |=> s.shift[0] == `FIXED_FILL)
        else $error("unused opportunity bit not at fill value");

    a_comm_first: assert property (s.phase == ds3_map_pkg::ASM_RUN && kind == ds3_map_pkg::KIND_COMM
                                   && s.bitIdx == 3'h4 |=> s.shift[0] == commPrev[1])
        else $error("first communication bit not taken from its input");

    a_comm_second: assert property (s.phase == ds3_map_pkg::ASM_RUN && kind == ds3_map_pkg::KIND_COMM
                                    && s.bitIdx == 3'h5 |=> s.shift[0] == commPrev[0])
        else $error("second communication bit not taken from its input");
endmodule // ds3_sts1_spe_mapper

`default_nettype wire

// file: src/ds3_map_params.svh
`ifndef DS3_MAP_PARAMS_SVH
`define DS3_MAP_PARAMS_SVH

// Envelope geometry
`define SPE_COLS 87
`define SPE_ROWS 9
`define TOH_COLS 3
`define FRAME_COLS 90
`define POH_COL 3

// Bit budget of one row and one envelope
`define FIXED_PER_ROW 59
`define DATA_PER_ROW 621
`define DATA_PER_SPE 5589
`define OPP_PER_ROW 1
`define CTRL_PER_ROW 5
`define COMM_PER_ROW 2
`define BITS_PER_SPE 5592
`define NOMINAL_DATA_OPP 3

// Payload byte positions inside a row, counted after the POH byte
`define IDX_FIX_A 0
`define IDX_FIX_B 28
`define IDX_FIX_C 56
`define IDX_FIX_D 83
`define IDX_FIX_E 84
`define IDX_CTRL_A 1
`define IDX_CTRL_B 29
`define IDX_CTRL_C 57
`define IDX_OPP 85

// Fill values
`define POH_FILL 8'h00
`define FIXED_FILL 1'b0

// Timing
`define SPE_PER_SEC 8000
`define SONET_CLK_KHZ 51840
`define SYS_CLK_KHZ 125000
`define BYTE_RATE_KHZ (`SONET_CLK_KHZ / 8)
`define SPE_PERIOD_CYC (`SYS_CLK_KHZ * 1000 / `SPE_PER_SEC)

// Buffering
`define FIFO_DEPTH 16

`endif

// file: src/ds3_map_pkg.sv
`default_nettype none
`include "ds3_map_params.svh"

package ds3_map_pkg;

    typedef enum logic [0:0] {ASM_IDLE, ASM_RUN} asm_phase_type;

    typedef enum logic [2:0] {KIND_FIXED, KIND_DATA, KIND_CTRL, KIND_OPP, KIND_COMM} bit_kind_type;

    typedef struct packed {
        logic [16:0] acc;
        logic [6:0] col;
        logic [3:0] row;
        asm_phase_type phase;
        logic [2:0] bitIdx;
        logic [6:0] idx;
        logic [7:0] shift;
        logic stuffData;
        logic signed [7:0] debt;
        logic [12:0] bitsIn;
        logic primed;
        logic [7:0] speByte;
        logic speValid;
        logic speFirst;
        logic pohSlot;
        logic underrun;
    } mapper_state_type;

    // Kind of bit b (0 = first sent) of payload byte idx
    function automatic bit_kind_type kind_of(input logic [6:0] idx, input logic [2:0] b);
        bit_kind_type k;
        k = KIND_DATA;
        if (idx == 7'(`IDX_FIX_A) || idx == 7'(`IDX_FIX_B) || idx == 7'(`IDX_FIX_C) ||
            idx == 7'(`IDX_FIX_D) || idx == 7'(`IDX_FIX_E)) begin
            k = KIND_FIXED;
        end else if (idx == 7'(`IDX_CTRL_A)) begin
            k = (b < 3'h2) ? KIND_FIXED : ((b == 3'h2) ? KIND_CTRL : KIND_DATA);
        end else if (idx == 7'(`IDX_CTRL_B)) begin
            k = (b < 3'h2) ? KIND_CTRL : ((b == 3'h4 || b == 3'h5) ? KIND_COMM : KIND_FIXED);
        end else if (idx == 7'(`IDX_CTRL_C)) begin
            k = (b < 3'h2) ? KIND_CTRL : KIND_FIXED;
        end else if (idx == 7'(`IDX_OPP)) begin
            k = (b == 3'h6) ? KIND_OPP : KIND_FIXED;
        end
        return k;
    endfunction

endpackage

`default_nettype wire

// file: src/stream_if.sv
`timescale 1ns/1ps
`default_nettype none

interface stream_if #(
    parameter int W = 8
) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// file: src/stream_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// DEPTH must be a power of two
module stream_fifo #(
    parameter int W = 1,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Fill side
    stream_if.snk inPort,
    // Drain side
    stream_if.src outPort
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
        logic notFull;
    } fifo_state_type;

    fifo_state_type s, next_s;
    logic push;
    logic drain;

    assign inPort.ready = s.notFull;
    assign outPort.valid = s.count != '0;
    assign outPort.data = s.mem[s.rd];

    always_comb begin
        next_s = s;
        push = inPort.valid && s.notFull;
        drain = (s.count != '0) && outPort.ready;
        if (push) begin
            next_s.mem[s.wr] = inPort.data;
            next_s.wr = s.wr + 1'b1;
        end
        if (drain) begin
            next_s.rd = s.rd + 1'b1;
        end
        if (push && !drain) begin
            next_s.count = s.count + 1'b1;
        end else if (drain && !push) begin
            next_s.count = s.count - 1'b1;
        end
        next_s.notFull = next_s.count != (AW+1)'(DEPTH);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s <= '0;
            s.notFull <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule // stream_fifo

`default_nettype wire

// file: dv/ds3_source_model.sv
`timescale 1ns/1ps
`default_nettype none

module ds3_source_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Bench control: low stalls the source
    input wire logic enable,
    // Link to the mapper
    input wire logic ready,
    output logic dataBit,
    output logic valid
);
    int unsigned sent = 0;
    logic taken = 1'b0;
    logic runLatched = 1'b0;
    logic enLatched = 1'b0;

    function automatic logic pattern_bit(input logic [31:0] n);
        return n[0] ^ n[2] ^ n[5] ^ n[9];
    endfunction

    initial begin
        valid = 1'b0;
        dataBit = 1'b0;
    end

    // Controls are latched on the rising edge so the bench's falling-edge updates never race
    always @(posedge clk) begin
        taken <= valid && ready && resetn;
        runLatched <= resetn;
        enLatched <= enable;
    end

    always @(negedge clk) begin
        if (!runLatched) begin
            valid = 1'b0;
            sent = 0;
        end else begin
            if (taken) begin
                sent = sent + 1;
            end
            if (valid && !taken) begin
                // Refused bit stays offered unchanged
            end else if (enLatched) begin
                valid = 1'b1;
                dataBit = pattern_bit(sent);
            end else begin
                // Released line keeps moving so no stale bit is seen
                valid = 1'b0;
                dataBit = ~dataBit;
            end
        end
    end
endmodule // ds3_source_model

`default_nettype wire

// file: dv/test_ds3_sts1_spe_mapper.sv
`timescale 1ns/1ps
`default_nettype none

module test_ds3_sts1_spe_mapper;
`define CHK(what, expv, gotv) begin comparisons++; if ((gotv) !== (expv)) begin miscompares++; \
$display("unexpected %s: expected %0h seen %0h", what, expv, gotv); end end

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic srcEnable = 1'b0;
    logic [1:0] commBits = 2'b00;
    logic ds3Bit;
    logic ds3Valid;
    logic ds3Ready;
    logic [7:0] speByte;
    logic speValid;
    logic speFirst;
    logic pohSlot;
    logic rowStuffData;
    logic underrun;
    int miscompares = 0;
    int comparisons = 0;
    int underSeen = 0;

    always #4 clk = ~clk;

    ds3_sts1_spe_mapper i_dut (.clk(clk), .resetn(resetn), .ds3Bit(ds3Bit), .ds3Valid(ds3Valid),
        .ds3Ready(ds3Ready), .commBits(commBits), .speByte(speByte), .speValid(speValid),
        .speFirst(speFirst), .pohSlot(pohSlot), .rowStuffData(rowStuffData), .underrun(underrun));

    ds3_source_model i_src (.clk(clk), .resetn(resetn), .enable(srcEnable), .ready(ds3Ready),
        .dataBit(ds3Bit), .valid(ds3Valid));

    task automatic wrap_up();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic logic flag_of(input int sel);
        case (sel)
            0: return speValid;
            1: return pohSlot;
            2: return speFirst;
            default: return !ds3Ready;
        endcase
    endfunction

    task automatic wait_flag(input int sel, input int limit, inout int cyc);
        int n;
        for (n = 0; n < limit; n++) begin
            @(negedge clk);
            cyc++;
            if (underrun === 1'b1) underSeen++;
            if (flag_of(sel) === 1'b1) return;
        end
        miscompares++;
        $display("unexpected timeout on flag %0d", sel);
        wrap_up();
    endtask

    // Bit kinds of a payload byte, first-sent bit first
    function automatic string layout(input int idx);
        case (idx)
            0, 28, 56, 83, 84: return "RRRRRRRR";
            1: return "RRCIIIII";
            29: return "CCRROORR";
            57: return "CCRRRRRR";
            85: return "RRRRRRSR";
            default: return "IIIIIIII";
        endcase
    endfunction

    task automatic test_reset();
        `CHK("ready in reset", 1'b1, ds3Ready)
        `CHK("byte strobe in reset", 1'b0, speValid)
        `CHK("underrun in reset", 1'b0, underrun)
        $display("test reset done");
    endtask

    task automatic test_envelopes();
        int env, row, col, b, cyc, dataCnt, sCnt, nextBit;
        string lay;
        logic expv;
        nextBit = 0;
        cyc = 0;
        underSeen = 0;
        commBits = 2'b10;
        wait_flag(2, 200, cyc);
        for (env = 0; env < 2; env++) begin
            dataCnt = 0;
            sCnt = 0;
            cyc = 0;
            for (row = 0; row < 9; row++) begin
                if (row > 0) wait_flag(0, 100, cyc);
                `CHK("poh slot", 1'b1, pohSlot)
                `CHK("poh byte", 8'h00, speByte)
                `CHK("envelope start", logic'(row == 0), speFirst)
                for (col = 0; col < 86; col++) begin
                    wait_flag(0, 40, cyc);
                    `CHK("payload slot", 1'b0, pohSlot)
                    lay = layout(col);
                    for (b = 0; b < 8; b++) begin
                        case (lay[b])
                            "R": expv = 1'b0;
                            "C": expv = !rowStuffData;
                            "O": expv = commBits[5-b];
                            "S": expv = rowStuffData ? i_src.pattern_bit(nextBit) : 1'b0;
                            default: expv = i_src.pattern_bit(nextBit);
                        endcase
                        if (lay[b] == "I" || (lay[b] == "S" && rowStuffData === 1'b1)) begin
                            nextBit++;
                            dataCnt++;
                        end
                        `CHK(lay.substr(b, b), expv, speByte[7-b])
                    end
                end
                `CHK("stuff row choice", logic'(row % 3 == 2), rowStuffData)
                if (rowStuffData === 1'b1) sCnt++;
            end
            wait_flag(0, 100, cyc);
            `CHK("next envelope start", 1'b1, speFirst)
            `CHK("envelope period", 15625, cyc)
            `CHK("data bits per envelope", 5592, dataCnt)
            `CHK("data opportunities", 3, sCnt)
            commBits = 2'b01;
        end
        `CHK("underrun pulses", 0, underSeen)
        $display("test envelopes done");
    endtask

    task automatic test_stall();
        int n, cyc;
        cyc = 0;
        underSeen = 0;
        srcEnable = 1'b0;
        for (n = 0; n < 4000; n++) begin
            @(negedge clk);
            if (underrun === 1'b1) underSeen++;
        end
        `CHK("starved slot flagged", 1'b1, logic'(underSeen > 0))
        `CHK("ready while empty", 1'b1, ds3Ready)
        srcEnable = 1'b1;
        wait_flag(3, 200, cyc);
        `CHK("ready when full", 1'b0, ds3Ready)
        wait_flag(2, 16000, cyc);
        for (n = 0; n < 9; n++) begin
            if (n > 0) wait_flag(1, 2000, cyc);
            @(negedge clk);
            `CHK("slow source stuffs", 1'b0, rowStuffData)
        end
        $display("test stall done");
    endtask

    initial begin
        repeat (8) @(negedge clk);
        test_reset();
        resetn = 1'b1;
        srcEnable = 1'b1;
        test_envelopes();
        test_stall();
        wrap_up();
    end
endmodule // test_ds3_sts1_spe_mapper

`default_nettype wire
